// ===== sao_alu.sv
// shader alu op subset: one-cycle registered datapath for a group of opcodes
// Summary of operation
// RULE_01 - unequal discard writes 1.0 and discards
// RULE_02 - discard only acts in pixel programs
// RULE_03 - issuer puts discard last in clause
// RULE_04 - exponent scale: mantissa times two power
// RULE_05 - all-ones exponent passes, zero gives signed zero
// RULE_06 - overflow gives infinity, else pack exp, sign
// RULE_07 - exponent scale uses slot pair 0-1/2-3
// RULE_08 - modifiers only in slot 0 or 2
// RULE_09 - byte average with third source rounding
// RULE_10 - flag load/store replaces and writes flags
// RULE_11 - flag load/store issued only in w
// RULE_12 - clamped log: negative infinity to most negative
// RULE_13 - ieee log: 1.0 gives 0, no clamp
// RULE_14 - left shift zero-fill, count above 31 zero
// RULE_15 - right shift uses low five count bits
// RULE_16 - max: single ge, double gt, +0 mixed zero; single max returns the first source on a mixed-zero tie
// RULE_17 - double max writes wz or yx pair
`timescale 1ns/1ps
module sao_alu
    import sao_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // instruction from the decoder
    input wire logic issue_i,
    input wire logic [7:0] opcode_i,
    input wire logic [2:0] slot_i,
    input wire logic pixel_program_i,
    input wire logic write_enable_i,
    input wire logic dst_pair_wz_i,
    input wire logic src0_negate_i,
    input wire logic src0_abs_i,
    input wire logic [1:0] output_scale_modifier_i,
    input wire logic [31:0] group_flags_i,
    // operands
    input wire logic [31:0] src0_i,
    input wire logic [31:0] src1_i,
    input wire logic [31:0] src2_i,
    input wire logic [63:0] src0_f64_i,
    input wire logic [63:0] src1_f64_i,
    // results
    output logic result_valid_o,
    output logic [63:0] result_o,
    output logic result_is_double_o,
    output logic result_write_o,
    output logic [3:0] result_lane_mask_o,
    output logic discard_o,
    output logic [31:0] flags_o
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic valid;
        logic [63:0] result;
        logic is_double;
        logic write;
        logic [3:0] lanes;
        logic discard;
        logic [31:0] flags;
    } sao_state_type;

    sao_state_type state_ff; // registered state
    sao_state_type nxt_state; // next state

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    // signed ordering key for ieee floats: flips so integer compare orders them
    function automatic logic [63:0] f64_key(input logic [63:0] v);
        f64_key = v[63] ? ~v : {1'b1, v[62:0]};
    endfunction

    function automatic logic [32:0] f32_key(input logic [31:0] v);
        f32_key = v[31] ? {1'b0, ~v} : {1'b1, v};
    endfunction

    function automatic logic f32_is_nan(input logic [31:0] v);
        f32_is_nan = (v[30:23] == 8'hFF) && (v[22:0] != 23'h0);
    endfunction

    // approximate log2: exponent as integer part, mantissa as linear fraction
    function automatic logic [31:0] approx_log2(input logic [31:0] v);
        logic signed [8:0] e;
        logic [30:0] mag;
        logic [31:0] fix;
        logic [4:0] msb;
        logic [7:0] bexp;
        e = 9'sd0;
        mag = 31'h0;
        fix = 32'h0;
        msb = 5'h0;
        bexp = 8'h0;
        approx_log2 = F32_ZERO;
        if (f32_is_nan(v) || (v[31] && v[30:0] != 31'h0)) begin
            approx_log2 = F32_QNAN; // negative input or nan
        end else if (v[30:23] == 8'h00) begin
            approx_log2 = F32_NEG_INF; // zero and denorm flush
        end else if (v[30:23] == 8'hFF) begin
            approx_log2 = F32_POS_INF;
        end else begin
            e = $signed({1'b0, v[30:23]}) - 9'sd127;
            // fixed point 8.23, sign separate
            fix = (e < 0) ? {1'b0, 8'(-e), 23'h0} - {9'h0, v[22:0]}
                          : {1'b0, 8'(e), v[22:0]};
            mag = fix[30:0];
            for (int i = 0; i < 31; i++) begin
                if (mag[i]) begin
                    msb = 5'(i);
                end
            end
            if (mag != 31'h0) begin
                bexp = 8'(8'd104 + 8'(msb)); // 127 - 23 + msb
                fix = {1'b0, mag} << (5'd30 - msb);
                approx_log2 = {e < 0, bexp, fix[29:7]};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic: one result per issued instruction
    logic [11:0] scaled_exp; // exponent after adding the scale, with headroom
    logic signed [33:0] exp_sum; // full signed sum of exponent and scale
    logic [31:0] src0_mod; // src0 after input modifiers
    logic mod_slot; // slot that owns sign bits for the double op
    logic [31:0] log_val; // raw log result

    always_comb begin
        nxt_state = state_ff;
        nxt_state.valid = issue_i;
        nxt_state.discard = 1'b0;
        nxt_state.write = 1'b0;
        scaled_exp = 12'h0;
        exp_sum = 34'sd0;
        log_val = approx_log2(src0_i);
        mod_slot = (slot_i == SLOT_X) || (slot_i == SLOT_Z); // see RULE_08
        src0_mod = src0_i;
        if (src0_abs_i) begin
            src0_mod[31] = 1'b0;
        end
        if (src0_negate_i) begin
            src0_mod[31] = ~src0_mod[31];
        end
        if (issue_i) begin
            nxt_state.is_double = 1'b0;
            nxt_state.write = write_enable_i;
            nxt_state.lanes = 4'h1 << slot_i[1:0];
            unique case (opcode_i)
                OP_FLOAT_DISCARD_IF_UNEQUAL, OP_INTEGER_DISCARD_IF_UNEQUAL: begin
                    // integer compare of bit patterns; float treats -0/+0 as equal and any nan as unequal
                    if ((opcode_i == OP_INTEGER_DISCARD_IF_UNEQUAL)
                        ? (src0_i != src1_i)
                        : (f32_is_nan(src0_i) || f32_is_nan(src1_i)
                           || (src0_mod != src1_i
                               && (src0_mod[30:0] | src1_i[30:0]) != 31'h0))) begin
                        nxt_state.result = {32'h0, F32_ONE}; // see RULE_01
                        nxt_state.discard = pixel_program_i; // see RULE_02
                    end else begin
                        nxt_state.result = {32'h0, F32_ZERO};
                    end
                    // other program types: the op is a no-op
                    if (!pixel_program_i) begin
                        nxt_state.write = 1'b0; // see RULE_02
                    end
                end
                OP_DOUBLE_EXPONENT_SCALE: begin
                    nxt_state.is_double = 1'b1;
                    // slot bit 1 picks the pair 0-1 or 2-3; any of slots 0-3 writes it
                    nxt_state.lanes = slot_i[1] ? 4'hC : 4'h3; // see RULE_07
                    if (slot_i == SLOT_T) begin
                        nxt_state.write = 1'b0; // see RULE_07
                    end
                    if (src1_f64_i[62:52] == F64_EXP_ALL_ONES) begin
                        nxt_state.result = src1_f64_i; // see RULE_05
                    end else if (src1_f64_i[62:52] == F64_EXP_ZERO) begin
                        nxt_state.result = {src1_f64_i[F64_SIGN_BIT], 63'h0}; // see RULE_05
                    end else begin
                        // scale exponent is a raw signed integer, no modifiers
                        exp_sum = 34'($signed({1'b0, src1_f64_i[62:52]}))
                                  + 34'($signed(src0_i)); // see RULE_04
                        scaled_exp = exp_sum[11:0];
                        if (exp_sum >= 34'sh7FF) begin
                            nxt_state.result = {src1_f64_i[F64_SIGN_BIT],
                                                F64_EXP_ALL_ONES, 52'h0}; // see RULE_06
                        end else if (exp_sum <= 34'sd0) begin
                            nxt_state.result = {src1_f64_i[F64_SIGN_BIT], 63'h0};
                        end else begin
                            nxt_state.result = {12'h0, src1_f64_i[51:0]}; // see RULE_04
                            nxt_state.result[F64_EXP_LSB +: 11] = scaled_exp[10:0]; // see RULE_06
                            nxt_state.result[F64_SIGN_BIT] = src1_f64_i[F64_SIGN_BIT]; // see RULE_06
                        end
                    end
                    // sign bits live in the even slot only
                    if (mod_slot && src0_negate_i) begin
                        nxt_state.result[F64_SIGN_BIT] = ~nxt_state.result[F64_SIGN_BIT]; // see RULE_08
                    end
                end
                OP_BYTE_AVERAGE: begin
                    for (int b = 0; b < 4; b++) begin
                        nxt_state.result[8*b +: 8] = 8'(({1'b0, src0_i[8*b +: 8]}
                            + {1'b0, src1_i[8*b +: 8]} + 9'(src2_i[8*b])) >> 1); // see RULE_09
                    end
                    nxt_state.result[63:32] = 32'h0;
                end
                OP_LOAD_STORE_FLAGS: begin
                    // written value includes this group's flags
                    nxt_state.result = {32'h0, state_ff.flags | group_flags_i}; // see RULE_10
                    nxt_state.flags = src0_i; // see RULE_10
                    if (slot_i != SLOT_W) begin
                        nxt_state.write = 1'b0; // see RULE_11
                        nxt_state.flags = state_ff.flags;
                    end
                end
                OP_BASE2_LOGARITHM_CLAMPED, OP_BASE2_LOGARITHM_IEEE: begin
                    if (src0_i == F32_ONE) begin
                        nxt_state.result = {32'h0, F32_ZERO}; // see RULE_12 see RULE_13
                    end else if (opcode_i == OP_BASE2_LOGARITHM_CLAMPED
                                 && log_val == F32_NEG_INF) begin
                        nxt_state.result = {32'h0, F32_NEG_MAX}; // see RULE_12
                    end else begin
                        nxt_state.result = {32'h0, log_val}; // see RULE_13
                    end
                end
                OP_LOGICAL_SHIFT_LEFT: begin
                    nxt_state.result = {32'h0, (src1_i > SHL_MAX_COUNT) ? 32'h0
                                        : src0_i << src1_i[4:0]}; // see RULE_14
                end
                OP_LOGICAL_SHIFT_RIGHT: begin
                    nxt_state.result = {32'h0, src0_i >> (src1_i[4:0] & SHR_COUNT_MASK)}; // see RULE_15
                end
                OP_MAX_F32: begin
                    // -0 and +0 count as equal, so the first source wins a mixed-zero tie
                    nxt_state.result = {32'h0, (f32_key(src0_mod) >= f32_key(src1_i)
                                        || (src0_mod[30:0] | src1_i[30:0]) == 31'h0)
                                        ? src0_mod : src1_i}; // see RULE_16
                end
                OP_MAX_F64: begin
                    nxt_state.is_double = 1'b1;
                    nxt_state.lanes = dst_pair_wz_i ? 4'hC : 4'h3; // see RULE_17
                    if (src0_f64_i[62:0] == 63'h0 && src1_f64_i[62:0] == 63'h0) begin
                        // any zero pairing with a positive zero yields +0
                        nxt_state.result = (src0_f64_i[63] & src1_f64_i[63])
                                           ? src0_f64_i : F64_POS_ZERO; // see RULE_16
                    end else begin
                        nxt_state.result = (f64_key(src0_f64_i) > f64_key(src1_f64_i))
                                           ? src0_f64_i : src1_f64_i; // see RULE_16
                    end
                end
                default: begin
                    // opcode outside this subset: no result written
                    nxt_state.write = 1'b0;
                    nxt_state.result = 64'h0;
                end
            endcase
            // output scale applies only to the double exponent scale op, and only in an even slot
            if (output_scale_modifier_i != 2'b00 && (!nxt_state.is_double || mod_slot)
                && nxt_state.result[62:52] != F64_EXP_ALL_ONES
                && opcode_i == OP_DOUBLE_EXPONENT_SCALE
                && nxt_state.result[62:52] != F64_EXP_ZERO) begin
                // 01: x2, 10: x4, 11: /2 on the exponent field
                nxt_state.result[62:52] = (output_scale_modifier_i == 2'b11)
                    ? nxt_state.result[62:52] - 11'h1
                    : nxt_state.result[62:52] + 11'(output_scale_modifier_i); // see RULE_08
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= '{valid: 1'b0, result: 64'h0, is_double: 1'b0, write: 1'b0,
                          lanes: 4'h0, discard: 1'b0, flags: FLAGS_RESET};
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    assign result_valid_o = state_ff.valid;
    assign result_o = state_ff.result;
    assign result_is_double_o = state_ff.is_double;
    assign result_write_o = state_ff.write;
    assign result_lane_mask_o = state_ff.lanes;
    assign discard_o = state_ff.discard;
    assign flags_o = state_ff.flags;
endmodule

// ===== sao_alu_checker.sv
// port-level assertions for the shader alu op subset
`timescale 1ns/1ps
module sao_alu_checker
    import sao_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // instruction and operands
    input wire logic issue_i,
    input wire logic [7:0] opcode_i,
    input wire logic [2:0] slot_i,
    input wire logic pixel_program_i,
    input wire logic dst_pair_wz_i,
    input wire logic [31:0] src0_i,
    input wire logic [31:0] src1_i,
    input wire logic [63:0] src1_f64_i,
    // results
    input wire logic [63:0] result_o,
    input wire logic result_write_o,
    input wire logic [3:0] result_lane_mask_o,
    input wire logic discard_o,
    input wire logic [31:0] flags_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // either unequal discard opcode
    wire logic kill_op = opcode_i == OP_FLOAT_DISCARD_IF_UNEQUAL ||
        opcode_i == OP_INTEGER_DISCARD_IF_UNEQUAL;
    //////////////////////////////////////////////////////////////////////////////
    property p_shl; issue_i && opcode_i == OP_LOGICAL_SHIFT_LEFT && src1_i <= 32'h1F
        |=> result_o == {32'h0, $past(src0_i) << $past(src1_i[4:0])}; endproperty
    a_shl: assert property (p_shl) else $error("left shift wrong");
    property p_shl_big; issue_i && opcode_i == OP_LOGICAL_SHIFT_LEFT && src1_i > 32'h1F
        |=> result_o == 64'h0; endproperty
    a_shl_big: assert property (p_shl_big) else $error("long left shift not zero");
    property p_shr; issue_i && opcode_i == OP_LOGICAL_SHIFT_RIGHT
        |=> result_o == {32'h0, $past(src0_i) >> $past(src1_i[4:0])}; endproperty
    a_shr: assert property (p_shr) else $error("right shift wrong");
    property p_kill_hit; issue_i && pixel_program_i && opcode_i == OP_INTEGER_DISCARD_IF_UNEQUAL
        && src0_i != src1_i |=> discard_o && result_o == {32'h0, F32_ONE}; endproperty
    a_kill_hit: assert property (p_kill_hit) else $error("discard missing");
    property p_kill_off; issue_i && !pixel_program_i && kill_op
        |=> !discard_o && !result_write_o; endproperty
    a_kill_off: assert property (p_kill_off) else $error("discard outside pixel");
    property p_flags; issue_i && opcode_i == OP_LOAD_STORE_FLAGS && slot_i == SLOT_W
        |=> flags_o == $past(src0_i); endproperty
    a_flags: assert property (p_flags) else $error("flags not loaded");
    property p_lanes; issue_i && opcode_i == OP_MAX_F64
        |=> result_lane_mask_o == ($past(dst_pair_wz_i) ? 4'hC : 4'h3); endproperty
    a_lanes: assert property (p_lanes) else $error("double max lanes wrong");
    property p_pass; issue_i && opcode_i == OP_DOUBLE_EXPONENT_SCALE && slot_i == SLOT_Y
        && src1_f64_i[62:52] == F64_EXP_ALL_ONES |=> result_o == $past(src1_f64_i); endproperty
    a_pass: assert property (p_pass) else $error("special exponent altered");
endmodule
bind sao_alu sao_alu_checker chk_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .issue_i(issue_i),
    .opcode_i(opcode_i), .slot_i(slot_i), .pixel_program_i(pixel_program_i),
    .dst_pair_wz_i(dst_pair_wz_i), .src0_i(src0_i), .src1_i(src1_i), .src1_f64_i(src1_f64_i),
    .result_o(result_o), .result_write_o(result_write_o),
    .result_lane_mask_o(result_lane_mask_o), .discard_o(discard_o), .flags_o(flags_o));

// ===== sao_decoder_model.sv
// decoder and operand source model issuing one alu instruction at a time
`timescale 1ns/1ps
module sao_decoder_model (
    // clock
    input wire logic sys_clk_i,
    // instruction toward the alu
    output logic issue_o,
    output logic [7:0] opcode_o,
    output logic [2:0] slot_o,
    output logic [6:0] ctl_o,
    // operands {src2, src1, src0}; src2 also carries group flags
    output logic [95:0] src_o,
    output logic [127:0] dbl_o
);
    initial begin
        {issue_o, opcode_o, slot_o, ctl_o, src_o, dbl_o} = '0;
    end
    // launch on a falling edge, release on the next one
    // discards go last, flag ops only in slot 3 unless a refusal is wanted
    // exponent scale kept to slot pairs 0-1 or 2-3 unless a refusal is wanted
    task automatic send(input logic [7:0] op, input logic [2:0] sl, input logic [6:0] c,
        input logic [95:0] s, input logic [127:0] d);
        @(negedge sys_clk_i);
        {issue_o, opcode_o, slot_o, ctl_o, src_o, dbl_o} = {1'b1, op, sl, c, s, d};
        @(negedge sys_clk_i);
        issue_o = 1'b0;
        // released operands go inverted so stale data cannot pass for valid
        {src_o, dbl_o} = ~{src_o, dbl_o};
    endtask
endmodule

// ===== sao_pkg.sv
// package: opcodes, field positions and float constants of the shader alu op subset
package sao_pkg;
    // alu opcodes (two- and three-operand spaces share this 8-bit field)
    localparam logic [7:0] OP_MAX_F32 = 8'h03;
    localparam logic [7:0] OP_BYTE_AVERAGE = 8'h0B;
    localparam logic [7:0] OP_LOGICAL_SHIFT_RIGHT = 8'h16;
    localparam logic [7:0] OP_LOGICAL_SHIFT_LEFT = 8'h17;
    localparam logic [7:0] OP_FLOAT_DISCARD_IF_UNEQUAL = 8'h2F;
    localparam logic [7:0] OP_INTEGER_DISCARD_IF_UNEQUAL = 8'h49;
    localparam logic [7:0] OP_BASE2_LOGARITHM_CLAMPED = 8'h82;
    localparam logic [7:0] OP_BASE2_LOGARITHM_IEEE = 8'h83;
    localparam logic [7:0] OP_MAX_F64 = 8'hBD;
    localparam logic [7:0] OP_DOUBLE_EXPONENT_SCALE = 8'hC5;
    localparam logic [7:0] OP_LOAD_STORE_FLAGS = 8'hDB;
    // single precision constants
    localparam logic [31:0] F32_ONE = 32'h3F800000;
    localparam logic [31:0] F32_ZERO = 32'h00000000;
    localparam logic [31:0] F32_NEG_INF = 32'hFF800000;
    localparam logic [31:0] F32_NEG_MAX = 32'hFF7FFFFF;
    localparam logic [31:0] F32_POS_INF = 32'h7F800000;
    localparam logic [31:0] F32_QNAN = 32'h7FC00000;
    // double precision field layout
    localparam int F64_EXP_LSB = 52;
    localparam int F64_SIGN_BIT = 63;
    localparam logic [10:0] F64_EXP_ALL_ONES = 11'h7FF;
    localparam logic [10:0] F64_EXP_ZERO = 11'h000;
    localparam logic [63:0] F64_POS_ZERO = 64'h0000000000000000;
    // shifts: largest legal left shift count, mask for right shift count
    localparam logic [31:0] SHL_MAX_COUNT = 32'h0000001F;
    localparam logic [4:0] SHR_COUNT_MASK = 5'h1F;
    // slot numbering within an instruction group
    localparam logic [2:0] SLOT_X = 3'h0;
    localparam logic [2:0] SLOT_Y = 3'h1;
    localparam logic [2:0] SLOT_Z = 3'h2;
    localparam logic [2:0] SLOT_W = 3'h3;
    localparam logic [2:0] SLOT_T = 3'h4;
    // reset value of the working exception flags
    localparam logic [31:0] FLAGS_RESET = 32'h00000000;
endpackage

// ===== tb_top.sv
// self-checking bench for the shader alu op subset
`timescale 1ns/1ps
module tb_top;
    import sao_pkg::*;
    // control sets {pixel, write, wz pair, negate, abs, output scale}
    localparam logic [6:0] PX = 7'h40;
    localparam logic [6:0] WE = 7'h20;
    localparam logic [6:0] WZ = 7'h10;
    localparam logic [6:0] NG = 7'h08;
    localparam logic [7:0] LDX = OP_DOUBLE_EXPONENT_SCALE;
    localparam logic [63:0] ONE = 64'h3F800000;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    int n_mismatch = 0;
    int check_count = 0;
    // per-scenario slot, third word and double operands
    logic [2:0] sl_q = 3'h0;
    logic [31:0] e3 = 32'h0;
    logic [63:0] dx = 64'h0;
    logic [63:0] dy = 64'h0;
    logic iss, vld, dbl, wr, disc;
    logic [7:0] op;
    logic [2:0] sl;
    logic [6:0] ctl;
    logic [95:0] src;
    logic [127:0] dd;
    logic [63:0] res;
    logic [3:0] lanes;
    logic [31:0] flg;
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    sao_decoder_model dec (.sys_clk_i(sys_clk_i), .issue_o(iss), .opcode_o(op), .slot_o(sl),
        .ctl_o(ctl), .src_o(src), .dbl_o(dd));
    sao_alu dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .issue_i(iss), .opcode_i(op),
        .slot_i(sl), .pixel_program_i(ctl[6]), .write_enable_i(ctl[5]), .dst_pair_wz_i(ctl[4]),
        .src0_negate_i(ctl[3]), .src0_abs_i(ctl[2]), .output_scale_modifier_i(ctl[1:0]),
        .group_flags_i(src[95:64]), .src0_i(src[31:0]), .src1_i(src[63:32]),
        .src2_i(src[95:64]), .src0_f64_i(dd[127:64]), .src1_f64_i(dd[63:0]),
        .result_valid_o(vld), .result_o(res), .result_is_double_o(dbl), .result_write_o(wr),
        .result_lane_mask_o(lanes), .discard_o(disc), .flags_o(flg));
    //////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one instruction; answer is checked half a cycle after the rising edge that takes it
    task automatic run(input logic [7:0] o, input logic [6:0] c, input logic [31:0] a, b,
        input logic [63:0] exp);
        dec.send(o, sl_q, c, {e3, b, a}, {dx, dy});
        chk(64'(vld), 64'h1);
        chk(res, exp);
        chk(64'(dbl), 64'(o == LDX || o == OP_MAX_F64));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////////
    task automatic t_shift();
        run(OP_LOGICAL_SHIFT_LEFT, WE, 32'h1, 32'h4, 64'h10);
        run(OP_LOGICAL_SHIFT_LEFT, WE, 32'hFFFFFFFF, 32'h1F, 64'h80000000);
        run(OP_LOGICAL_SHIFT_LEFT, WE, 32'h1, 32'h20, 64'h0);
        run(OP_LOGICAL_SHIFT_RIGHT, WE, 32'h80000000, 32'h3F, 64'h1);
        run(OP_LOGICAL_SHIFT_RIGHT, WE, 32'hF0, 32'h24, 64'hF);
    endtask
    task automatic t_discard();
        run(OP_FLOAT_DISCARD_IF_UNEQUAL, PX | WE, F32_ONE, 32'h40000000, ONE);
        chk(64'(disc), 64'h1);
        run(OP_FLOAT_DISCARD_IF_UNEQUAL, PX | WE, 32'h80000000, 32'h0, 64'h0);
        chk(64'(disc), 64'h0);
        run(OP_INTEGER_DISCARD_IF_UNEQUAL, PX | WE, 32'h5, 32'h6, ONE);
        dec.send(OP_INTEGER_DISCARD_IF_UNEQUAL, 3'h0, WE, 96'h600000005, 128'h0);
        chk({62'h0, disc, wr}, 64'h0);
    endtask
    task automatic t_avg_flags();
        e3 = 32'h00000101;
        run(OP_BYTE_AVERAGE, WE, 32'hFF010203, 32'h01010304, 64'h80010304);
        e3 = 32'h00000100;
        sl_q = SLOT_W;
        // stored word is the flags held before the load, plus this group's
        run(OP_LOAD_STORE_FLAGS, WE, 32'hA5, 32'h0, 64'h100);
        chk({32'h0, flg}, 64'hA5);
        dec.send(OP_LOAD_STORE_FLAGS, SLOT_Y, WE, 96'h3C, 128'h0);
        chk({31'h0, wr, flg}, 64'hA5);
        run(OP_LOAD_STORE_FLAGS, WE, 32'h0, 32'h0, 64'h1A5);
        chk({32'h0, flg}, 64'h0);
        sl_q = SLOT_X;
    endtask
    task automatic t_log_max();
        run(OP_BASE2_LOGARITHM_CLAMPED, WE, F32_ONE, 32'h0, 64'h0);
        run(OP_BASE2_LOGARITHM_CLAMPED, WE, F32_ZERO, 32'h0, {32'h0, F32_NEG_MAX});
        run(OP_BASE2_LOGARITHM_IEEE, WE, F32_ONE, 32'h0, 64'h0);
        run(OP_BASE2_LOGARITHM_IEEE, WE, F32_ZERO, 32'h0, {32'h0, F32_NEG_INF});
        run(OP_MAX_F32, WE, 32'h80000000, 32'h0, 64'h80000000);
        run(OP_MAX_F32, WE, F32_ONE, 32'h40000000, 64'h40000000);
        dy = 64'h8000000000000000;
        run(OP_MAX_F64, WE | WZ, 32'h0, 32'h0, 64'h0);
        chk({60'h0, lanes}, 64'hC);
        {dx, dy} = {64'h4000000000000000, 64'h3FF0000000000000};
        run(OP_MAX_F64, WE, 32'h0, 32'h0, 64'h4000000000000000);
        chk({60'h0, lanes}, 64'h3);
    endtask
    task automatic t_ldexp();
        dy = 64'h47F000006FC6A731;
        run(LDX, WE, 32'h2C6, 32'h0, 64'h745000006FC6A731);
        chk({60'h0, lanes}, 64'h3);
        sl_q = SLOT_Z;
        // output scale x2 in an even slot bumps the exponent by one
        run(LDX, WE | 7'h01, 32'h2C6, 32'h0, 64'h746000006FC6A731);
        chk({60'h0, lanes}, 64'hC);
        dy = 64'hC7EFFFFEE072B19F;
        sl_q = SLOT_Z;
        run(LDX, WE | NG, 32'h15E, 32'h0, 64'h5DCFFFFEE072B19F);
        sl_q = SLOT_Y;
        // negate plus double output scale, both ignored in slot 1
        run(LDX, 7'h29, 32'h15E, 32'h0, 64'hDDCFFFFEE072B19F);
        dy = 64'h7FF0000000000001;
        run(LDX, WE, 32'h5, 32'h0, 64'h7FF0000000000001);
        dy = 64'h8000000000000005;
        run(LDX, WE, 32'h3, 32'h0, 64'h8000000000000000);
        dy = 64'h7FE0000000000000;
        run(LDX, WE, 32'h1, 32'h0, 64'h7FF0000000000000);
        dec.send(LDX, SLOT_T, WE, 96'h1, {64'h0, dy});
        chk(64'(wr), 64'h0);
        sl_q = SLOT_X;
    endtask
    // hang guard: far above the cycles the sequence needs
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        nrst_i = 1'b1;
        t_shift();
        t_discard();
        t_avg_flags();
        t_log_max();
        t_ldexp();
        tally_and_finish();
    end
endmodule
